// file: pkg/ccbm_pkg.sv
// Purpose: shared constants for the coupled coprocessor bus master
// Assumes: one core clock, asynchronous active-low reset
// Notes:   command encodings and field layouts of the coupled bus
`default_nettype none
package ccbm_pkg;
  localparam int unsigned CMD_W   = 8;
  localparam int unsigned REG_W   = 4;
  localparam int unsigned BLK_W   = 4;
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned CPNO_W  = 3;

  localparam logic [7:0] CMD_IDLE    = 8'h00;
  localparam logic [7:0] CMD_WRITE_W = 8'h01;
  localparam logic [7:0] CMD_WRITE_D = 8'h02;
  localparam logic [7:0] CMD_READ_W  = 8'h03;
  localparam logic [7:0] CMD_READ_D  = 8'h04;
  localparam logic [7:0] CMD_SYS_WR  = 8'h05;
  localparam logic [7:0] CMD_SYS_RD  = 8'h06;
  localparam logic [7:0] CMD_DBG_WR  = 8'h07;
  localparam logic [7:0] CMD_DBG_RD  = 8'h08;
  localparam logic [7:0] CMD_TT_RD   = 8'h09;
  localparam logic [7:0] CMD_TT_SRCH = 8'h0a;
  localparam logic [7:0] CMD_TT_WR   = 8'h0b;
  localparam logic [7:0] CMD_COP_MIN = 8'h80;

  localparam logic [3:0]  REG_RST  = 4'h0;
  localparam logic [31:0] DATA_RST = 32'h0000_0000;

  // request kinds presented by the core pipeline
  typedef enum logic [3:0] {
    CCBM_K_WRITE_W = 4'h0,
    CCBM_K_WRITE_D = 4'h1,
    CCBM_K_READ_W  = 4'h2,
    CCBM_K_READ_D  = 4'h3,
    CCBM_K_SYS_WR  = 4'h4,
    CCBM_K_SYS_RD  = 4'h5,
    CCBM_K_DBG_WR  = 4'h6,
    CCBM_K_DBG_RD  = 4'h7,
    CCBM_K_TT_RD   = 4'h8,
    CCBM_K_TT_SRCH = 4'h9,
    CCBM_K_TT_WR   = 4'ha,
    CCBM_K_COP     = 4'hb
  } ccbm_kind_e;

  // low nibble of a system or debug register number
  function automatic logic [3:0] ccbm_lo_nib(input logic [7:0] n);
    return n[3:0];
  endfunction : ccbm_lo_nib

  function automatic logic [3:0] ccbm_hi_nib(input logic [7:0] n);
    return n[7:4];
  endfunction : ccbm_hi_nib

  function automatic logic ccbm_is_read(input logic [3:0] k);
    return (k == 4'(CCBM_K_READ_W)) || (k == 4'(CCBM_K_READ_D)) ||
           (k == 4'(CCBM_K_SYS_RD)) || (k == 4'(CCBM_K_DBG_RD)) ||
           (k == 4'(CCBM_K_TT_RD))  || (k == 4'(CCBM_K_TT_SRCH));
  endfunction : ccbm_is_read
endpackage : ccbm_pkg
`default_nettype wire

// file: rtl/ccbm_encode.sv
// Purpose: combinational encoder from a core request to bus fields
// Assumes: request fields are stable while presented
// Notes:   pure decode, no state
`default_nettype none
`timescale 1ns/100ps
module ccbm_encode
  import ccbm_pkg::*;
(
  input  wire logic [3:0]  kind_in,     // request kind
  input  wire logic [3:0]  regnum_in,   // target or source register
  input  wire logic [7:0]  sysnum_in,   // system or debug register number
  input  wire logic [2:0]  cpno_in,     // coprocessor number
  input  wire logic [6:0]  copop_in,    // coprocessor opcode low bits
  input  wire logic [3:0]  cpregb_in,   // coprocessor operand b
  input  wire logic [3:0]  cpregc_in,   // coprocessor operand c
  output logic      [7:0]  cmd_out,     // encoded command
  output logic      [3:0]  rega_out,    // operand field a
  output logic      [3:0]  regb_out,    // operand field b
  output logic      [3:0]  regc_out,    // operand field c
  output logic      [3:0]  blk_out,     // block-number field
  output logic             dbl_out      // double-word write
);
  wire logic [3:0] reg_plus1 = 4'(regnum_in + 4'h1);
  wire logic       is_sysdbg = (kind_in >= 4'(CCBM_K_SYS_WR)) &&
                               (kind_in <= 4'(CCBM_K_DBG_RD));

  always_comb begin
    cmd_out  = CMD_IDLE;
    rega_out = REG_RST;
    regb_out = REG_RST;
    regc_out = REG_RST;
    blk_out  = REG_RST;
    dbl_out  = 1'b0;
    case (kind_in)
      4'(CCBM_K_WRITE_W): begin
        cmd_out  = CMD_WRITE_W;
        rega_out = regnum_in;
      end
      4'(CCBM_K_WRITE_D): begin
        cmd_out  = CMD_WRITE_D;
        rega_out = reg_plus1;
        regb_out = regnum_in;
        dbl_out  = 1'b1;
      end
      4'(CCBM_K_READ_W): begin
        cmd_out  = CMD_READ_W;
        rega_out = regnum_in;
      end
      4'(CCBM_K_READ_D): begin
        cmd_out  = CMD_READ_D;
        rega_out = reg_plus1;
        regb_out = regnum_in;
      end
      4'(CCBM_K_SYS_WR): cmd_out = CMD_SYS_WR;
      4'(CCBM_K_SYS_RD): cmd_out = CMD_SYS_RD;
      4'(CCBM_K_DBG_WR): cmd_out = CMD_DBG_WR;
      4'(CCBM_K_DBG_RD): cmd_out = CMD_DBG_RD;
      4'(CCBM_K_TT_RD):   cmd_out = CMD_TT_RD;
      4'(CCBM_K_TT_SRCH): cmd_out = CMD_TT_SRCH;
      4'(CCBM_K_TT_WR):   cmd_out = CMD_TT_WR;
      4'(CCBM_K_COP): begin
        cmd_out  = CMD_COP_MIN | {1'b0, copop_in};
        rega_out = regnum_in;
        regb_out = cpregb_in;
        regc_out = cpregc_in;
        blk_out  = {1'b0, cpno_in};
      end
      default: cmd_out = CMD_IDLE;
    endcase
    if (is_sysdbg) begin
      rega_out = ccbm_lo_nib(sysnum_in);
      blk_out  = ccbm_hi_nib(sysnum_in);
    end
  end
endmodule : ccbm_encode
`default_nettype wire

// file: rtl/ccbm_master.sv
// Purpose: core-side master of the tightly coupled coprocessor bus
// Assumes: slaves answer through a ready handshake on the core clock
// Notes:   address phase overlaps the previous data phase
//
// Behaviour
// - core is the only bus initiator
// - slave waits stretch phases until ready
// - address phase then data phase, pipelined
// - command 0 idle, 1 single write
// - command 2 double write, A=reg+1, B=reg
// - command 3 single read on A
// - command 4 double read, A=reg+1, B=reg
// - command 5 system write, split number
// - command 6 system read, split number
// - command 7 debug write, split number
// - command 8 debug read, split number
// - commands 9-11 translation ops, fields unused
// - commands 128-255 carry coprocessor opcode
// - coprocessor number on block bits 2:0
// - register moves use block bits 3:0
// - eight coprocessors, sixteen register blocks
// - double write: A high word, B low
// - flush flag one cycle after flush
// - stall flag one cycle after stall
`default_nettype none
`timescale 1ns/100ps
module ccbm_master
  import ccbm_pkg::*;
(
  input  wire logic        mclk_in,        // core clock, 200 MHz
  input  wire logic        reset_n_in,     // async reset, active low
  input  wire logic        ce_in,          // clock enable, freezes state
  // core request side
  input  wire logic        req_valid_in,   // core presents a request
  input  wire logic [3:0]  req_kind_in,    // request kind
  input  wire logic [3:0]  req_reg_in,     // target/source register
  input  wire logic [7:0]  req_sysnum_in,  // system/debug register no
  input  wire logic [2:0]  req_cpno_in,    // coprocessor number
  input  wire logic [6:0]  req_copop_in,   // coprocessor opcode bits
  input  wire logic [3:0]  req_cpregb_in,  // coprocessor operand b
  input  wire logic [3:0]  req_cpregc_in,  // coprocessor operand c
  input  wire logic [63:0] req_wdata_in,   // write data, high word first
  output logic             req_ready_out,  // request taken at the previous edge
  output logic             rsp_valid_out,  // read answer valid, 1 cycle
  output logic [31:0]      rsp_dataa_out,  // read word a
  output logic [31:0]      rsp_datab_out,  // read word b
  input  wire logic        ls_flush_in,    // load/store pipe flushed
  input  wire logic        ls_stall_in,    // load/store pipe stalled
  // bus side
  output logic [7:0]       tcb_cmd_out,    // command
  output logic [3:0]       tcb_rega_out,   // operand field a
  output logic [3:0]       tcb_regb_out,   // operand field b
  output logic [3:0]       tcb_regc_out,   // operand field c
  output logic [3:0]       tcb_blk_out,    // block number
  output logic [31:0]      tcb_wdataa_out, // write data a
  output logic [31:0]      tcb_wdatab_out, // write data b
  input  wire logic        tcb_ready_in,   // slave accepts/answers
  input  wire logic [31:0] tcb_rdataa_in,  // read data a
  input  wire logic [31:0] tcb_rdatab_in,  // read data b
  output logic             tcb_flushed_out,// pipe flushed last cycle
  output logic             tcb_stalled_out // pipe stalled last cycle
);
  typedef enum logic [1:0] {
    CCBM_S_IDLE = 2'b01,
    CCBM_S_BUSY = 2'b10
  } ccbm_state_e;

  ccbm_state_e state_q, state_d;
  logic [7:0]  cmd_q;
  logic [3:0]  rega_q, regb_q, regc_q, blk_q;
  logic [31:0] wa_q, wb_q;
  logic [3:0]  req_kind_q; // kind of the phase on the bus
  logic        rv_q;
  logic [31:0] ra_q, rb_q;

  logic [7:0]  enc_cmd;
  logic [3:0]  enc_a, enc_b, enc_c, enc_blk;
  logic        enc_dbl;

  ccbm_encode u_enc (
    .kind_in   (req_kind_in),
    .regnum_in (req_reg_in),
    .sysnum_in (req_sysnum_in),
    .cpno_in   (req_cpno_in),
    .copop_in  (req_copop_in),
    .cpregb_in (req_cpregb_in),
    .cpregc_in (req_cpregc_in),
    .cmd_out   (enc_cmd),
    .rega_out  (enc_a),
    .regb_out  (enc_b),
    .regc_out  (enc_c),
    .blk_out   (enc_blk),
    .dbl_out   (enc_dbl)
  );

  ccbm_pulse u_flush (
    .mclk_in    (mclk_in),
    .reset_n_in (reset_n_in),
    .ce_in      (ce_in),
    .event_in   (ls_flush_in),
    .flag_out   (tcb_flushed_out)
  );

  ccbm_pulse u_stall (
    .mclk_in    (mclk_in),
    .reset_n_in (reset_n_in),
    .ce_in      (ce_in),
    .event_in   (ls_stall_in),
    .flag_out   (tcb_stalled_out)
  );

  // the phase on the bus completes when the slave says ready
  wire logic phase_done = (state_q == CCBM_S_BUSY) && tcb_ready_in;
  // a new address phase may issue when bus idle or current one completes
  wire logic can_issue  = (state_q == CCBM_S_IDLE) || phase_done;
  wire logic take       = ce_in && req_valid_in && can_issue;
  wire logic is_rd      = ccbm_is_read(req_kind_in);
  wire logic cur_rd     = ccbm_is_read(req_kind_q);

  always_comb begin
    state_d = state_q;
    case (state_q)
      CCBM_S_IDLE: if (req_valid_in) state_d = CCBM_S_BUSY;
      CCBM_S_BUSY: if (tcb_ready_in && !req_valid_in) state_d = CCBM_S_IDLE;
      default:     state_d = CCBM_S_IDLE;
    endcase
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q <= CCBM_S_IDLE;
    end else if (ce_in) begin
      state_q <= state_d;
    end
  end

  // address-phase fields; held while the slave waits
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cmd_q      <= CMD_IDLE;
      rega_q     <= REG_RST;
      regb_q     <= REG_RST;
      regc_q     <= REG_RST;
      blk_q      <= REG_RST;
      req_kind_q <= REG_RST;
    end else if (take) begin
      cmd_q      <= enc_cmd;
      rega_q     <= enc_a;
      regb_q     <= enc_b;
      regc_q     <= enc_c;
      blk_q      <= enc_blk;
      req_kind_q <= req_kind_in;
    end else if (ce_in && can_issue) begin
      cmd_q      <= CMD_IDLE;
    end
  end

  // write data: a carries the high word; b zero on single writes
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wa_q <= DATA_RST;
      wb_q <= DATA_RST;
    end else if (take && !is_rd) begin
      wa_q <= req_wdata_in[63:32];
      wb_q <= enc_dbl ? req_wdata_in[31:0] : DATA_RST;
    end
  end

  // read answers are captured in the completing data phase
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rv_q  <= 1'b0;
      ra_q  <= DATA_RST;
      rb_q  <= DATA_RST;
    end else if (ce_in) begin
      rv_q  <= phase_done && cur_rd;
      if (phase_done && cur_rd) begin
        ra_q <= tcb_rdataa_in;
        rb_q <= tcb_rdatab_in;
      end
    end
  end

  logic rdy_q;
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdy_q <= 1'b0;
    end else if (ce_in) begin
      // held with the rest of the state while enable is low
      rdy_q <= take;
    end
  end

  assign req_ready_out   = rdy_q;
  assign rsp_valid_out   = rv_q;
  assign rsp_dataa_out   = ra_q;
  assign rsp_datab_out   = rb_q;
  assign tcb_cmd_out     = cmd_q;
  assign tcb_rega_out    = rega_q;
  assign tcb_regb_out    = regb_q;
  assign tcb_regc_out    = regc_q;
  assign tcb_blk_out     = blk_q;
  assign tcb_wdataa_out  = wa_q;
  assign tcb_wdatab_out  = wb_q;
endmodule : ccbm_master
`default_nettype wire

// file: rtl/ccbm_pulse.sv
// Purpose: one-cycle-delayed status flag toward the slaves
// Assumes: event input is on the core clock
// Notes:   reports what happened in the previous cycle
`default_nettype none
`timescale 1ns/100ps
module ccbm_pulse (
  input  wire logic mclk_in,     // core clock
  input  wire logic reset_n_in,  // async reset, active low
  input  wire logic ce_in,       // clock enable
  input  wire logic event_in,    // pipeline event this cycle
  output logic      flag_out     // event seen last cycle
);
  logic flag_q;
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      flag_q <= 1'b0;
    end else if (ce_in) begin
      flag_q <= event_in;
    end
  end
  assign flag_out = flag_q;
endmodule : ccbm_pulse
`default_nettype wire

// file: verification/ccbm_master_properties.sv
// Purpose: concurrent checks on the coupled bus master ports
// Assumes: one clock domain, async active-low reset
// Notes:   bound to every ccbm_master instance
`default_nettype none
`timescale 1ns/100ps
module ccbm_master_properties (
  input wire logic        mclk_in,         // clock
  input wire logic        reset_n_in,      // reset
  input wire logic        ce_in,           // enable
  input wire logic        req_valid_in,    // request
  input wire logic        req_ready_out,   // taken
  input wire logic        rsp_valid_out,   // answer
  input wire logic [31:0] rsp_dataa_out,   // answer a
  input wire logic        ls_flush_in,     // flush
  input wire logic        ls_stall_in,     // stall
  input wire logic [7:0]  tcb_cmd_out,     // command
  input wire logic [3:0]  tcb_rega_out,    // field a
  input wire logic [3:0]  tcb_regb_out,    // field b
  input wire logic [3:0]  tcb_regc_out,    // field c
  input wire logic [3:0]  tcb_blk_out,     // block
  input wire logic [31:0] tcb_wdataa_out,  // data a
  input wire logic [31:0] tcb_wdatab_out,  // data b
  input wire logic        tcb_ready_in,    // slave ready
  input wire logic [31:0] tcb_rdataa_in,   // read a
  input wire logic        tcb_flushed_out, // flushed
  input wire logic        tcb_stalled_out  // stalled
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  wire logic busy;
  wire logic rd_cmd;
  logic      take_q;
  assign busy = tcb_cmd_out != 8'h00;
  assign rd_cmd = tcb_cmd_out inside {8'h03, 8'h04, 8'h06, 8'h08, 8'h09,
                                      8'h0a};
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) take_q <= 1'b0;
    else if (ce_in) take_q <= req_valid_in & (!busy | tcb_ready_in);
  end
  a_ready_on_take: assert property (req_ready_out == take_q)
    else $error("ready pulse without a take");
  a_reset_idle: assert property ($rose(reset_n_in) |-> !busy)
    else $error("command not idle after reset");
  a_hold_wait: assert property (busy && !tcb_ready_in |=>
    $stable({tcb_cmd_out, tcb_rega_out, tcb_regb_out, tcb_regc_out,
             tcb_blk_out, tcb_wdataa_out, tcb_wdatab_out}))
    else $error("fields moved during wait");
  a_idle_done: assert property (ce_in && busy && tcb_ready_in
    && !req_valid_in |=> !busy)
    else $error("command not idle after last phase");
  a_dbl_pair: assert property (tcb_cmd_out inside {8'h02, 8'h04} |->
    tcb_rega_out == tcb_regb_out + 4'h1)
    else $error("double field a is not b plus one");
  a_cop_block: assert property (tcb_cmd_out[7] |-> !tcb_blk_out[3])
    else $error("coprocessor number above seven");
  a_cmd_legal: assert property (tcb_cmd_out[7] || tcb_cmd_out <= 8'h0b)
    else $error("reserved command value");
  a_rsp_read: assert property (ce_in && tcb_ready_in && rd_cmd |=>
    rsp_valid_out && rsp_dataa_out == $past(tcb_rdataa_in))
    else $error("read answer missing or wrong");
  a_flush_delay: assert property (ce_in |=>
    tcb_flushed_out == $past(ls_flush_in))
    else $error("flush flag not one cycle late");
  a_stall_delay: assert property (ce_in |=>
    tcb_stalled_out == $past(ls_stall_in))
    else $error("stall flag not one cycle late");
endmodule : ccbm_master_properties
bind ccbm_master ccbm_master_properties u_props (
  .mclk_in(mclk_in), .reset_n_in(reset_n_in), .ce_in(ce_in),
  .req_valid_in(req_valid_in), .req_ready_out(req_ready_out),
  .rsp_valid_out(rsp_valid_out), .rsp_dataa_out(rsp_dataa_out),
  .ls_flush_in(ls_flush_in), .ls_stall_in(ls_stall_in),
  .tcb_cmd_out(tcb_cmd_out), .tcb_rega_out(tcb_rega_out),
  .tcb_regb_out(tcb_regb_out), .tcb_regc_out(tcb_regc_out),
  .tcb_blk_out(tcb_blk_out), .tcb_wdataa_out(tcb_wdataa_out),
  .tcb_wdatab_out(tcb_wdatab_out), .tcb_ready_in(tcb_ready_in),
  .tcb_rdataa_in(tcb_rdataa_in), .tcb_flushed_out(tcb_flushed_out),
  .tcb_stalled_out(tcb_stalled_out));
`default_nettype wire

// file: verification/ccbm_master_tb.sv
// Purpose: self-checking bench for the coupled bus master
// Assumes: bench model tracks phases from its own takes
// Notes:   all kinds, boundary fields, waits, gaps, enable low
`default_nettype none
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, e); end end
module ccbm_master_tb;
  import ccbm_pkg::*;
  logic mclk_in = 0, reset_n_in = 0, ce_in = 1, req_valid_in = 0;
  logic [3:0] req_kind_in = 0, req_reg_in = 0, req_cpregb_in = 0;
  logic [3:0] req_cpregc_in = 0, rega, regb, regc, blk;
  logic [7:0] req_sysnum_in = 0, cmd;
  logic [2:0] req_cpno_in = 0;
  logic [6:0] req_copop_in = 0;
  logic [63:0] req_wdata_in = 0, rd_q;
  logic ls_flush_in = 0, ls_stall_in = 0, rdy, req_ready_out, rsp_valid_out;
  logic [31:0] rsp_dataa_out, rsp_datab_out, wda, wdb, rda, rdb, seed, wd;
  logic flo, sto, busy = 0, take_q = 0, rsp_q = 0, fl_q = 0, st_q = 0, t;
  logic [1:0] waits_in = 0;
  logic [87:0] cur = 0, exp_w;
  int checks = 0, n_mismatch = 0;
  wire logic take_w = req_valid_in & ce_in & (!busy | rdy);
  function automatic logic [87:0] fld(input logic [3:0] k, r, b, c,
    input logic [7:0] s, input logic [2:0] n, input logic [6:0] o,
    input logic [63:0] w);
    logic d, sr;
    d = k == 4'h1 || k == 4'h3;
    sr = k inside {[4'h4:4'h7]};
    return {k == 4'hb ? {1'b1, o} : {4'h0, k + 4'h1},
      d ? r + 4'h1 : k inside {4'h0, 4'h2, 4'hb} ? r : sr ? s[3:0] : 4'h0,
      d ? r : k == 4'hb ? b : 4'h0, k == 4'hb ? c : 4'h0,
      sr ? s[7:4] : k == 4'hb ? {1'b0, n} : 4'h0,
      w[63:32], k == 4'h1 ? w[31:0] : 32'h0};
  endfunction : fld
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  assign exp_w = fld(req_kind_in, req_reg_in, req_cpregb_in, req_cpregc_in,
    req_sysnum_in, req_cpno_in, req_copop_in, req_wdata_in);
  assign wd = {cur[87:80], cur[67:64], cur[79:72], 12'h5a3};
  ccbm_master dut (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
    .ce_in(ce_in), .req_valid_in(req_valid_in), .req_kind_in(req_kind_in),
    .req_reg_in(req_reg_in), .req_sysnum_in(req_sysnum_in),
    .req_cpno_in(req_cpno_in), .req_copop_in(req_copop_in),
    .req_cpregb_in(req_cpregb_in), .req_cpregc_in(req_cpregc_in),
    .req_wdata_in(req_wdata_in), .req_ready_out(req_ready_out),
    .rsp_valid_out(rsp_valid_out), .rsp_dataa_out(rsp_dataa_out),
    .rsp_datab_out(rsp_datab_out), .ls_flush_in(ls_flush_in),
    .ls_stall_in(ls_stall_in), .tcb_cmd_out(cmd), .tcb_rega_out(rega),
    .tcb_regb_out(regb), .tcb_regc_out(regc), .tcb_blk_out(blk),
    .tcb_wdataa_out(wda), .tcb_wdatab_out(wdb), .tcb_ready_in(rdy),
    .tcb_rdataa_in(rda), .tcb_rdatab_in(rdb), .tcb_flushed_out(flo),
    .tcb_stalled_out(sto));
  ccbm_slave_model u_slave (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
    .ce_in(ce_in), .waits_in(waits_in), .cmd_in(cmd), .rega_in(rega),
    .regb_in(regb), .blk_in(blk), .ready_out(rdy), .rdataa_out(rda),
    .rdatab_out(rdb));
  always #2.5 mclk_in = ~mclk_in;
  always @(posedge mclk_in) begin
    if (reset_n_in && ce_in) begin
      take_q <= take_w;
      fl_q <= ls_flush_in;
      st_q <= ls_stall_in;
      rsp_q <= busy & rdy & (cur[87:80] inside {8'h03, 8'h04, 8'h06,
        8'h08, 8'h09, 8'h0a});
      rd_q <= {wd, ~wd};
      busy <= take_w | (busy & !rdy);
      if (take_w) cur <= exp_w;
    end
  end
  always @(negedge mclk_in) begin
    if (!reset_n_in) `CHK(cmd, 8'h00)
    else begin
      `CHK(req_ready_out, take_q)
      `CHK(rsp_valid_out, rsp_q)
      `CHK({flo, sto}, {fl_q, st_q})
      `CHK(cmd, busy ? cur[87:80] : 8'h00)
      if (busy) `CHK({rega, regb, regc, blk}, cur[79:64])
      if (busy && cmd inside {1, 2, 5, 7}) `CHK(wda, cur[63:32])
      if (busy && cmd inside {1, 2}) `CHK(wdb, cur[31:0])
      if (rsp_q) `CHK({rsp_dataa_out, rsp_datab_out}, rd_q)
    end
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    seed = 32'hd55f4a64;
    repeat (16) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    for (int i = 0; i < 36; i++) begin
      seed = lfsr(seed);
      req_valid_in <= 1'b1;
      req_kind_in <= 4'(i % 12);
      req_reg_in <= i / 12 == 1 ? 4'hf : seed[3:0];
      req_sysnum_in <= i / 12 == 1 ? 8'hff : seed[11:4];
      req_cpno_in <= i / 12 == 1 ? 3'h7 : seed[14:12];
      req_copop_in <= i / 12 == 1 ? 7'h7f : seed[21:15];
      {req_cpregb_in, req_cpregc_in} <= seed[29:22];
      req_wdata_in <= {seed, ~seed};
      {ls_flush_in, ls_stall_in} <= seed[31:30];
      do begin
        @(negedge mclk_in);
        t = take_w;
        @(posedge mclk_in);
      end while (!t);
      waits_in <= seed[1:0];
      if (i >= 24) begin
        req_valid_in <= 1'b0;
        ce_in <= i != 30;
        repeat (1 + i % 3) @(posedge mclk_in);
        ce_in <= 1'b1;
      end
    end
    req_valid_in <= 1'b0;
    repeat (10) @(posedge mclk_in);
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge mclk_in);
    n_mismatch++;
    end_of_test();
  end
endmodule : ccbm_master_tb
`undef CHK
`default_nettype wire

// file: verification/ccbm_slave_model.sv
// Purpose: responding slave on the coupled bus
// Assumes: waits_in changes only when a phase starts
// Notes:   read data is a tag of the addressed fields
`default_nettype none
`timescale 1ns/100ps
module ccbm_slave_model (
  input  wire logic        mclk_in,     // clock
  input  wire logic        reset_n_in,  // reset
  input  wire logic        ce_in,       // enable
  input  wire logic [1:0]  waits_in,    // wait states
  input  wire logic [7:0]  cmd_in,      // command
  input  wire logic [3:0]  rega_in,     // field a
  input  wire logic [3:0]  regb_in,     // field b
  input  wire logic [3:0]  blk_in,      // block
  output logic             ready_out,   // reply
  output logic      [31:0] rdataa_out,  // read a
  output logic      [31:0] rdatab_out   // read b
);
  logic [1:0]  cnt_q;
  wire logic   busy;
  wire logic [31:0] word;
  // only answers a command, never starts one
  assign busy = cmd_in != 8'h00;
  assign ready_out = busy && cnt_q == waits_in;
  assign word = {cmd_in, blk_in, rega_in, regb_in, 12'h5a3};
  // data not valid outside the reply cycle
  assign rdataa_out = ready_out ? word : ~word;
  assign rdatab_out = ready_out ? ~word : word;
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) cnt_q <= 2'h0;
    else if (ce_in) cnt_q <= ready_out ? 2'h0 : cnt_q + 2'(busy);
  end
endmodule : ccbm_slave_model
`default_nettype wire
